/* hdl/cit_pkg.sv */
// Purpose: Shared constants and types for the core instruction timing block
// Assumes: Single clock, synchronous active-low reset
// Notes:   Opcode values follow the standard encoding of this 8-bit core family
`default_nettype none
package cit_pkg;

  // ==========================================================================
  // Opcodes, and group prefixes whose low bits select register or pointer
  // ==========================================================================
  localparam logic [7:0] OP_XRL_DIR_A   = 8'h62;
  localparam logic [7:0] OP_XRL_DIR_IMM = 8'h63;
  localparam logic [7:0] OP_XRL_A_IMM   = 8'h64;
  localparam logic [7:0] OP_CLR_A       = 8'hE4;
  localparam logic [7:0] OP_CPL_A       = 8'hF4;
  localparam logic [7:0] OP_RL_A        = 8'h23;
  localparam logic [7:0] OP_RLC_A       = 8'h33;
  localparam logic [7:0] OP_RR_A        = 8'h03;
  localparam logic [7:0] OP_RRC_A       = 8'h13;
  localparam logic [7:0] OP_SWAP_A      = 8'hC4;
  localparam logic [7:0] OP_MOV_A_IMM   = 8'h74;
  localparam logic [7:0] OP_MOV_A_DIR   = 8'hE5;
  localparam logic [7:0] OP_MOV_DIR_A   = 8'hF5;
  localparam logic [7:0] OP_MOV_DIR_DIR = 8'h85;
  localparam logic [7:0] OP_MOV_DIR_IMM = 8'h75;
  localparam logic [7:0] OP_MOV_DPTR    = 8'h90;
  localparam logic [7:0] OP_MOVC_DPTR   = 8'h93;
  localparam logic [7:0] OP_MOVC_PC     = 8'h83;
  localparam logic [7:0] OP_MOVX_A_DP   = 8'hE0;
  localparam logic [7:0] OP_MOVX_DP_A   = 8'hF0;
  localparam logic [7:0] OP_PUSH        = 8'hC0;
  localparam logic [7:0] OP_POP         = 8'hD0;
  localparam logic [7:0] OP_XCH_A_DIR   = 8'hC5;
  // Upper five bits for register forms, upper seven bits for pointer forms
  localparam logic [4:0] GR_MOV_A_RN    = 5'h1D;
  localparam logic [4:0] GR_MOV_RN_A    = 5'h1F;
  localparam logic [4:0] GR_MOV_RN_DIR  = 5'h15;
  localparam logic [4:0] GR_MOV_RN_IMM  = 5'h0F;
  localparam logic [4:0] GR_MOV_DIR_RN  = 5'h11;
  localparam logic [4:0] GR_XCH_A_RN    = 5'h19;
  localparam logic [6:0] GP_MOV_A_RI    = 7'h73;
  localparam logic [6:0] GP_MOV_RI_A    = 7'h7B;
  localparam logic [6:0] GP_MOV_DIR_RI  = 7'h43;
  localparam logic [6:0] GP_MOV_RI_DIR  = 7'h53;
  localparam logic [6:0] GP_MOV_RI_IMM  = 7'h3B;
  localparam logic [6:0] GP_MOVX_A_RI   = 7'h71;
  localparam logic [6:0] GP_MOVX_RI_A   = 7'h79;
  localparam logic [6:0] GP_XCH_A_RI    = 7'h63;
  localparam logic [6:0] GP_XCHD_A_RI   = 7'h6B;

  // ==========================================================================
  // Lengths and nominal cycle counts
  // ==========================================================================
  localparam logic [1:0] LEN_0 = 2'h0;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam int         TIMING_W = 3;

  // Accumulator operations
  typedef enum logic [3:0] {
    CIT_ALU_NONE = 4'h0,
    CIT_ALU_XRL  = 4'h1,
    CIT_ALU_CLR  = 4'h2,
    CIT_ALU_CPL  = 4'h3,
    CIT_ALU_RL   = 4'h4,
    CIT_ALU_RLC  = 4'h5,
    CIT_ALU_RR   = 4'h6,
    CIT_ALU_RRC  = 4'h7,
    CIT_ALU_SWAP = 4'h8,
    CIT_ALU_XCHD = 4'h9
  } cit_alu_t;

  // Decode result
  typedef struct packed {
    logic       known;
    logic [1:0] bytes;
    logic [3:0] cycles;
    cit_alu_t   alu;
    logic       code_rd;
    logic       xdata_rd;
    logic       xdata_wr;
    logic       wide_addr;
  } cit_dec_t;

  // Accumulator result
  typedef struct packed {
    logic [7:0] acc;
    logic       carry;
    logic [7:0] mem;
  } cit_res_t;

endpackage : cit_pkg
`default_nettype wire

/* hdl/cit_alu.sv */
// Purpose: Accumulator logic, rotate and nibble operations
// Assumes: Purely combinational, used by the timing block
// Notes:   Memory result only meaningful for digit exchange
`default_nettype none
module cit_alu
  import cit_pkg::*;
(
  // Operation
  input  wire cit_alu_t   op,
  // Operands
  input  wire logic [7:0] acc,
  input  wire logic       carry,
  input  wire logic [7:0] operand,
  // Result
  output cit_res_t        res
);

  always_comb begin
    res = '{acc: acc, carry: carry, mem: operand};
    case (op)
      CIT_ALU_XRL:  res.acc = acc ^ operand;
      CIT_ALU_CLR:  res.acc = 8'h00;
      CIT_ALU_CPL:  res.acc = ~acc;
      CIT_ALU_RL:   res.acc = {acc[6:0], acc[7]};
      CIT_ALU_RR:   res.acc = {acc[0], acc[7:1]};
      CIT_ALU_RLC: begin
        res.acc   = {acc[6:0], carry};
        res.carry = acc[7];
      end
      CIT_ALU_RRC: begin
        res.acc   = {carry, acc[7:1]};
        res.carry = acc[0];
      end
      CIT_ALU_SWAP: res.acc = {acc[3:0], acc[7:4]};
      CIT_ALU_XCHD: begin
        res.acc = {acc[7:4], operand[3:0]};
        res.mem = {operand[7:4], acc[3:0]};
      end
      default:      res.acc = acc;
    endcase
  end

endmodule // cit_alu
`default_nettype wire

/* hdl/cit_timing.sv */
// Purpose: Decode, byte length and cycle timing for a core instruction subset
// Assumes: Opcode and operands presented with a start pulse; one clock
// Notes:   Sequencer holds each known instruction for its cycle count plus the extra stall
`default_nettype none
module cit_timing
  import cit_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Instruction request
  input  wire logic                start,
  input  wire logic [7:0]          opcode,
  input  wire logic [7:0]          operand,
  input  wire logic [7:0]          acc_in,
  input  wire logic                carry_in,
  input  wire logic [15:0]         dptr,
  input  wire logic [15:0]         pc,
  input  wire logic [7:0]          ptr_reg,
  // Variable timing
  input  wire logic [TIMING_W-1:0] flash_read_timing,
  input  wire logic                misaligned,
  // Status
  output logic                     busy,
  output logic                     done,
  output logic                     pass_on,
  output logic [1:0]               inst_bytes,
  output logic [3:0]               inst_cycles,
  // Results
  output logic [7:0]               acc_out,
  output logic                     carry_out,
  output logic [7:0]               mem_out,
  // Memory access
  output logic                     code_rd,
  output logic                     xdata_rd,
  output logic                     xdata_wr,
  output logic [15:0]              mem_addr
);

  // ==========================================================================
  // Decode function
  // ==========================================================================
  function automatic cit_dec_t decode(input logic [7:0] op);
    cit_dec_t d;
    d = '{known: 1'b1, bytes: LEN_1, cycles: CYC_1, alu: CIT_ALU_NONE,
          code_rd: 1'b0, xdata_rd: 1'b0, xdata_wr: 1'b0, wide_addr: 1'b0};
    if (op == OP_XRL_A_IMM || op == OP_XRL_DIR_A) begin
      d.bytes = LEN_2; d.cycles = CYC_2; d.alu = CIT_ALU_XRL;
    end else if (op == OP_XRL_DIR_IMM) begin
      d.bytes = LEN_3; d.cycles = CYC_3; d.alu = CIT_ALU_XRL;
    end else if (op == OP_CLR_A) d.alu = CIT_ALU_CLR;
    else if (op == OP_CPL_A)  d.alu = CIT_ALU_CPL;
    else if (op == OP_RL_A)   d.alu = CIT_ALU_RL;
    else if (op == OP_RLC_A)  d.alu = CIT_ALU_RLC;
    else if (op == OP_RR_A)   d.alu = CIT_ALU_RR;
    else if (op == OP_RRC_A)  d.alu = CIT_ALU_RRC;
    else if (op == OP_SWAP_A) d.alu = CIT_ALU_SWAP;
    else if (op[7:3] == GR_MOV_A_RN || op[7:3] == GR_MOV_RN_A
             || op[7:3] == GR_XCH_A_RN) begin
      d.bytes = LEN_1; d.cycles = CYC_1;
    end else if (op[7:3] == GR_MOV_RN_DIR || op[7:3] == GR_MOV_RN_IMM) begin
      d.bytes = LEN_2; d.cycles = CYC_2;
    end else if (op[7:1] == GP_MOV_A_RI || op[7:1] == GP_MOV_RI_A
             || op[7:1] == GP_XCH_A_RI) begin
      d.bytes = LEN_1; d.cycles = CYC_2;
    end else if (op[7:1] == GP_XCHD_A_RI) begin
      d.bytes = LEN_1; d.cycles = CYC_2; d.alu = CIT_ALU_XCHD;
    end else if (op == OP_MOV_A_DIR || op == OP_MOV_A_IMM || op == OP_MOV_DIR_A
             || op[7:3] == GR_MOV_DIR_RN || op[7:1] == GP_MOV_DIR_RI
             || op[7:1] == GP_MOV_RI_DIR || op[7:1] == GP_MOV_RI_IMM) begin
      d.bytes = LEN_2; d.cycles = CYC_2;
    end else if (op == OP_MOV_DIR_DIR || op == OP_MOV_DIR_IMM) begin
      d.bytes = LEN_3; d.cycles = CYC_3;
    end else if (op == OP_MOV_DPTR) begin
      d.bytes = LEN_3; d.cycles = CYC_3;
    end else if (op == OP_MOVC_DPTR || op == OP_MOVC_PC) begin
      d.cycles = CYC_3; d.code_rd = 1'b1;
      d.wide_addr = (op == OP_MOVC_DPTR);
    end else if (op == OP_MOVX_A_DP || op == OP_MOVX_DP_A) begin
      d.cycles = CYC_3; d.wide_addr = 1'b1;
      d.xdata_rd = (op == OP_MOVX_A_DP);
      d.xdata_wr = (op == OP_MOVX_DP_A);
    end else if (op[7:1] == GP_MOVX_A_RI || op[7:1] == GP_MOVX_RI_A) begin
      d.cycles = CYC_3;
      d.xdata_rd = (op[7:1] == GP_MOVX_A_RI);
      d.xdata_wr = (op[7:1] == GP_MOVX_RI_A);
    end else if (op == OP_PUSH || op == OP_POP) begin
      d.bytes = LEN_2; d.cycles = CYC_2;
    end else if (op == OP_XCH_A_DIR) begin
      d.bytes = LEN_2; d.cycles = CYC_2;
    end else begin
      d.known = 1'b0; d.bytes = LEN_0; d.cycles = CYC_1;
    end
    return d;
  endfunction

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  typedef enum logic [1:0] {
    CIT_IDLE = 2'b01,
    CIT_EXEC = 2'b10
  } cit_state_t;

  cit_state_t state;
  cit_dec_t   cur_dec;
  cit_res_t   alu_res;
  logic [3:0] remain;
  logic [3:0] extra;
  logic [7:0] op_acc;
  logic       op_carry;
  logic [7:0] op_operand;
  cit_dec_t   new_dec;

  // Opcode is decoded every cycle; the result is only used on a take
  assign new_dec = decode(opcode);
  // Extra stall: one cycle when misaligned, plus the flash read timing value
  assign extra   = 4'(misaligned) + 4'(flash_read_timing);

  // Works on captured operands, so the result stays put during execution
  cit_alu u_alu (
    .op      (cur_dec.alu),
    .acc     (op_acc),
    .carry   (op_carry),
    .operand (op_operand),
    .res     (alu_res)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state  <= CIT_IDLE;
      remain <= 4'h0;
    end else begin
      case (state)
        CIT_IDLE: begin
          // A start while busy never reaches this branch and is ignored
          if (start && new_dec.known) begin
            state  <= CIT_EXEC;
            remain <= 4'(new_dec.cycles + extra - CYC_1);
          end
        end
        CIT_EXEC: begin
          if (remain == 4'h0) state <= CIT_IDLE;
          else remain <= remain - CYC_1;
        end
        default: state <= CIT_IDLE;
      endcase
    end
  end

  // Operand capture
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur_dec    <= '0;
      op_acc     <= 8'h00;
      op_carry   <= 1'b0;
      op_operand <= 8'h00;
      mem_addr   <= 16'h0000;
    end else if (state == CIT_IDLE && start) begin
      cur_dec    <= new_dec;
      op_acc     <= acc_in;
      op_carry   <= carry_in;
      op_operand <= operand;
      if (new_dec.code_rd)
        mem_addr <= 16'((new_dec.wide_addr ? dptr : pc) + {8'h00, acc_in});
      else if (new_dec.wide_addr)
        mem_addr <= dptr;
      else
        mem_addr <= {8'h00, ptr_reg};
    end
  end

  // Outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      done        <= 1'b0;
      pass_on     <= 1'b0;
      inst_bytes  <= LEN_0;
      inst_cycles <= 4'h0;
      acc_out     <= 8'h00;
      carry_out   <= 1'b0;
      mem_out     <= 8'h00;
    end else begin
      // Done pulse and results land on the edge that ends execution
      done    <= (state == CIT_EXEC) && (remain == 4'h0);
      pass_on <= (state == CIT_IDLE) && start && !new_dec.known;
      if (state == CIT_IDLE && start) begin
        inst_bytes  <= new_dec.bytes;
        inst_cycles <= new_dec.cycles;
      end
      if (state == CIT_EXEC && remain == 4'h0) begin
        acc_out   <= alu_res.acc;
        carry_out <= alu_res.carry;
        mem_out   <= alu_res.mem;
      end
    end
  end

  // Access strobes follow the decoded kind for the whole execution
  assign busy     = (state == CIT_EXEC);
  assign code_rd  = busy && cur_dec.code_rd;
  assign xdata_rd = busy && cur_dec.xdata_rd;
  assign xdata_wr = busy && cur_dec.xdata_wr;

endmodule // cit_timing
`default_nettype wire

/* tb/cit_mem_model.sv */
// Purpose: Internal RAM byte seen through the pointer register
// Assumes: Fixed contents, read without delay
// Notes:   Internal RAM operand for the digit exchange test
`default_nettype none
module cit_mem_model (
  // Address
  input  wire logic [7:0] ptr_reg,
  // Data
  output logic      [7:0] ram_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ram [256];
  initial foreach (ram[i]) ram[i] = 8'(i * 7) ^ 8'hA3;
  assign ram_data = ram[ptr_reg];
endmodule // cit_mem_model
`default_nettype wire

/* tb/cit_timing_props.sv */
// Purpose: Timing and result properties of the decode block
// Assumes: One clock, synchronous active-low reset
// Notes:   Captures the request at each take
`default_nettype none
module cit_timing_props
  import cit_pkg::*;
(
  // Clock, reset and request
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic                start,
  input wire logic [7:0]          opcode,
  input wire logic [7:0]          operand,
  input wire logic [7:0]          acc_in,
  input wire logic [15:0]         dptr,
  input wire logic [TIMING_W-1:0] flash_read_timing,
  input wire logic                misaligned,
  // Status and results
  input wire logic                busy,
  input wire logic                done,
  input wire logic                pass_on,
  input wire logic [1:0]          inst_bytes,
  input wire logic [3:0]          inst_cycles,
  input wire logic [7:0]          acc_out,
  input wire logic                code_rd,
  input wire logic                xdata_rd,
  input wire logic [15:0]         mem_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  op_q, acc_q, opnd_q;
  logic [15:0] dptr_q;
  logic [4:0]  ext_q, cnt;
  wire logic   take = start && !busy;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {op_q, acc_q, opnd_q, dptr_q, ext_q} <= '0;
    end else if (take) begin
      {op_q, acc_q, opnd_q, dptr_q} <= {opcode, acc_in, operand, dptr};
      ext_q <= 5'(flash_read_timing) + 5'(misaligned);
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn || take) begin
      cnt <= 5'h00;
    end else if (busy) begin
      cnt <= cnt + 5'h01;
    end
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_clr_latency: assert property (
    take && opcode == OP_CLR_A && flash_read_timing == '0 && !misaligned
    |=> busy ##1 (done && !busy && acc_out == 8'h00)) else $error("clear timing");
  a_stall_count: assert property (
    done |-> cnt == 5'(inst_cycles) + ext_q) else $error("stall count");
  a_xrl_result: assert property (
    done && op_q == OP_XRL_A_IMM |-> acc_out == (acc_q ^ opnd_q)) else $error("xor");
  a_swap_result: assert property (
    done && op_q == OP_SWAP_A |-> acc_out == {acc_q[3:0], acc_q[7:4]}) else $error("swap");
  a_movx_addr: assert property (
    take && opcode == OP_MOVX_A_DP |=> xdata_rd && mem_addr == dptr_q) else $error("movx");
  a_movc_addr: assert property (
    take && opcode == OP_MOVC_DPTR |=> code_rd && mem_addr == dptr_q + {8'h00, acc_q})
    else $error("movc address");
  a_pass_unknown: assert property (
    pass_on |-> !busy && inst_bytes == LEN_0 && inst_cycles == CYC_1) else $error("pass");
  a_dptr_load: assert property (
    take && opcode == OP_MOV_DPTR && flash_read_timing == '0 && !misaligned
    |=> (inst_bytes == LEN_3 && inst_cycles == CYC_3) ##0 busy[*3] ##1 done)
    else $error("pointer load");
  c_pass: cover property (pass_on);
  c_stall: cover property (done && ext_q != 5'h00);
  c_xrl: cover property (done && op_q == OP_XRL_A_IMM);
endmodule // cit_timing_props
bind cit_timing cit_timing_props u_props (.clk, .resetn, .start, .opcode, .operand,
  .acc_in, .dptr, .flash_read_timing, .misaligned, .busy, .done, .pass_on, .inst_bytes,
  .inst_cycles, .acc_out, .code_rd, .xdata_rd, .mem_addr);
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the decode and timing block
// Assumes: 100 MHz clock, reset low for 20 cycles
// Notes:   Inputs change 1 ns after each rising edge
`default_nettype none
module tb
  import cit_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                clk, resetn, start, carry_in, misaligned, bsy;
  logic [7:0]          opcode, operand, acc_in, ptr_reg, ram_data, acc_out, mem_out;
  logic [15:0]         dptr, pc, mem_addr;
  logic [TIMING_W-1:0] frt;
  logic                busy, done, pass_on, carry_out, code_rd, xdata_rd, xdata_wr;
  logic [1:0]          inst_bytes;
  logic [3:0]          inst_cycles;
  logic [18:0]         snap;
  int                  mismatches, n_compared, lat;
  cit_timing uut (.clk, .resetn, .start, .opcode, .operand, .acc_in, .carry_in, .dptr, .pc,
    .ptr_reg, .flash_read_timing(frt), .misaligned, .busy, .done, .pass_on, .inst_bytes,
    .inst_cycles, .acc_out, .carry_out, .mem_out, .code_rd, .xdata_rd, .xdata_wr, .mem_addr);
  cit_mem_model u_mem (.ptr_reg, .ram_data);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic cmp(input logic [19:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_n(input int got, exp);
    cmp(20'(got), 20'(exp));
  endtask
  task automatic go(input logic [7:0] op, a, o);
    opcode = op;
    acc_in = a;
    operand = o;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    snap = {code_rd, xdata_rd, xdata_wr, mem_addr};
    bsy = busy;
    lat = 1;
    while (done !== 1'b1 && pass_on !== 1'b1 && lat < 40) begin
      @(posedge clk);
      #1 lat++;
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_table;
    logic [15:0] t [38] = '{16'h6422, 16'h6222, 16'h6333, 16'hE411, 16'hF411, 16'h2311,
      16'h3311, 16'h0311, 16'h1311, 16'hC411, 16'hE911, 16'hE522, 16'hE612, 16'h7422,
      16'hFF11, 16'hAA22, 16'h7D22, 16'hF522, 16'h8B22, 16'h8533, 16'h8722, 16'h7533,
      16'hF712, 16'hA622, 16'h7722, 16'h9033, 16'h9313, 16'h8313, 16'hE313, 16'hF213,
      16'hE013, 16'hF013, 16'hC022, 16'hD022, 16'hCE11, 16'hC522, 16'hC712, 16'hD612};
    foreach (t[i]) begin
      go(t[i][15:8], 8'h11, 8'h22);
      cmp(20'(bsy), 20'h1);
      cmp(20'(inst_bytes), 20'(t[i][7:4]));
      cmp(20'(inst_cycles), 20'(t[i][3:0]));
      cmp_n(lat, int'(t[i][3:0]) + 1);
    end
    $display("t_table finished");
  endtask
  task automatic t_acc;
    logic [15:0] t [8] = '{16'hE400, 16'hF44A, 16'h236B, 16'h336A, 16'h03DA, 16'h135A,
      16'hC45B, 16'h64EA};
    foreach (t[i]) begin
      go(t[i][15:8], 8'hB5, 8'h5F);
      cmp(20'(acc_out), 20'(t[i][7:0]));
      if (t[i][15:8] inside {OP_RLC_A, OP_RRC_A}) cmp(20'(carry_out), 20'h1);
    end
    carry_in = 1'b1;
    go(OP_RLC_A, 8'h35, 8'h00);
    cmp(20'({carry_out, acc_out}), 20'h0006B);
    go(OP_RRC_A, 8'h35, 8'h00);
    cmp(20'({carry_out, acc_out}), 20'h0019A);
    carry_in = 1'b0;
    $display("t_acc finished");
  endtask
  task automatic t_xchd;
    go(8'hD7, 8'hB5, ram_data);
    cmp(20'(acc_out), {12'h000, 4'hB, ram_data[3:0]});
    cmp(20'(mem_out), {12'h000, ram_data[7:4], 4'h5});
    $display("t_xchd finished");
  endtask
  task automatic t_addr;
    logic [27:0] t [6] = '{28'h93412E9, 28'h834F1A5, 28'hE32009C, 28'hF21009C,
      28'hE021234, 28'hF011234};
    dptr = 16'h1234;
    pc = 16'hF0F0;
    foreach (t[i]) begin
      go(t[i][27:20], 8'hB5, 8'h00);
      cmp(20'(snap), 20'(t[i][18:0]));
    end
    $display("t_addr finished");
  endtask
  task automatic t_stall;
    logic [19:0] t [3] = '{20'hE4316, 20'hE070B, 20'h90015};
    foreach (t[i]) begin
      frt = t[i][10:8];
      misaligned = t[i][4];
      go(t[i][19:12], 8'h00, 8'h00);
      cmp_n(lat, int'(t[i][3:0]));
    end
    frt = '0;
    misaligned = 1'b0;
    $display("t_stall finished");
  endtask
  task automatic t_unknown;
    go(8'h00, 8'h00, 8'h00);
    cmp_n(lat, 1);
    cmp(20'(bsy), 20'h0);
    cmp(20'({inst_bytes, inst_cycles}), 20'h01);
    @(posedge clk);
    #1 cmp(20'(pass_on), 20'h0);
    $display("t_unknown finished");
  endtask
  // ==========================================================================
  // Clock, watchdog and main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
  initial begin
    {resetn, start, carry_in, misaligned, opcode, operand, acc_in} = '0;
    {dptr, pc, frt} = '0;
    ptr_reg = 8'h9C;
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    t_table;
    t_acc;
    t_xchd;
    t_addr;
    t_stall;
    t_unknown;
    print_verdict;
  end
endmodule // tb
`default_nettype wire
